// >>> bench/host_wake_model.sv
/*
 * host side model: a controller that sleeps until the alert level wakes it.
 * assumes: alert comes from the block on sys_clk, reset is synchronous.
 */
`timescale 1ns/1ps
`default_nettype none

module host_wake_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic alert,
    output logic [7:0] wake_count
);
    logic alert_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            alert_reg <= 1'b0;
            wake_count <= 8'h00;
        end else begin
            alert_reg <= alert;
            // a level that stays high is one wake-up, not one per cycle
            if (alert && !alert_reg) begin
                wake_count <= wake_count + 8'h01;
            end
        end
    end
endmodule

`default_nettype wire

// >>> bench/tb_top.sv
/*
 * self-checking bench for the window compare and alert capture block.
 * assumes: design package compiled first; one 250 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import window_compare_pkg::*;
    logic sys_clk, rst, conv_valid, conv_ready, conv_chan, monitor_enable;
    logic flag_clear_we, capture_restart, alert, capture_done;
    logic under_flag_ch0, under_flag_ch1, over_flag_ch0, over_flag_ch1;
    logic [3:0] consecutive_hit_limit, first_trigger_channel_id;
    logic [7:0] under_flag_clear, over_flag_clear, wake_count;
    sample_t conv_data, low_threshold_ch0, low_threshold_ch1, buf_rd_data;
    sample_t high_threshold_ch0, high_threshold_ch1;
    capture_mode_e capture_mode;
    buf_addr_t buf_rd_addr, buf_oldest_ptr;
    sample_t mem [16];
    int nwr = 0;
    int n_errors = 0;
    int num_checks = 0;

    window_compare_alert_capture u_window_compare_alert_capture (.sys_clk, .rst,
        .conv_valid, .conv_ready, .conv_data, .conv_chan, .monitor_enable, .capture_mode,
        .consecutive_hit_limit, .low_threshold_ch0, .low_threshold_ch1, .high_threshold_ch0,
        .high_threshold_ch1, .flag_clear_we, .under_flag_clear, .over_flag_clear,
        .capture_restart, .alert, .under_flag_ch0, .under_flag_ch1, .over_flag_ch0,
        .over_flag_ch1, .first_trigger_channel_id, .capture_done, .buf_rd_addr,
        .buf_rd_data, .buf_oldest_ptr);
    host_wake_model u_host_wake_model (.sys_clk, .rst, .alert, .wake_count);

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // leaves valid high so back-to-back words never toggle it in one step
    task automatic send(input logic ch, input sample_t v);
        int k;
        k = 0;
        conv_chan = ch;
        conv_data = v;
        conv_valid = 1'b1;
        while (conv_ready !== 1'b1 && k < 50) begin
            step(1);
            k++;
        end
        if (k == 50) chk("conv_ready", conv_ready, 12'h001);
        step(1);
    endtask

    task automatic put(input logic ch, input sample_t v);
        send(ch, v);
        conv_valid = 1'b0;
        step(3);
    endtask

    task automatic hput(input sample_t v);
        mem[nwr % 16] = v;
        nwr++;
        put(1'b0, v);
    endtask

    task automatic rdchk(input int a, input sample_t exp);
        buf_rd_addr = a[3:0];
        step(1);
        chk("buf_rd_data", buf_rd_data, exp);
    endtask

    task automatic clr(input logic [7:0] u, input logic [7:0] o);
        under_flag_clear = u;
        over_flag_clear = o;
        flag_clear_we = 1'b1;
        step(1);
        flag_clear_we = 1'b0;
        step(1);
    endtask

    task automatic restart(input capture_mode_e m);
        capture_mode = m;
        capture_restart = 1'b1;
        step(1);
        capture_restart = 1'b0;
        step(2);
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        {rst, conv_valid, conv_data, conv_chan} = {1'b1, 1'b0, 12'h000, 1'b0};
        {flag_clear_we, under_flag_clear, over_flag_clear, capture_restart} = '0;
        {monitor_enable, buf_rd_addr, consecutive_hit_limit} = {1'b1, 4'h0, 4'h2};
        capture_mode = MODE_HISTORY;
        {low_threshold_ch0, high_threshold_ch0} = {12'h064, 12'h0c8};
        {low_threshold_ch1, high_threshold_ch1} = {12'h000, 12'hfff};
        step(16);
        rst = 1'b0;
        chk("alert", alert, 12'h000);
        chk("flags", {under_flag_ch0, under_flag_ch1, over_flag_ch0, over_flag_ch1}, 12'h000);
        chk("chid", first_trigger_channel_id, 12'h000);
        chk("capture_done", capture_done, 12'h000);
        $display("test reset done");
        // history capture, need of three hits, high side at its boundary
        for (int i = 0; i < 20; i++) hput(12'h06e + i[11:0]);
        hput(12'h0c8);
        hput(12'h0c8);
        hput(12'h096);
        chk("alert", alert, 12'h000);
        hput(12'h0c8);
        hput(12'h0c8);
        chk("alert", alert, 12'h000);
        hput(12'h0c8);
        chk("alert", alert, 12'h001);
        chk("over_flag_ch0", over_flag_ch0, 12'h001);
        chk("under_flag_ch0", under_flag_ch0, 12'h000);
        chk("chid", first_trigger_channel_id, 12'h000);
        chk("capture_done", capture_done, 12'h001);
        put(1'b0, 12'h055);
        chk("under_flag_ch0", under_flag_ch0, 12'h001);
        for (int a = 0; a < 16; a++) rdchk(a, mem[a]);
        chk("buf_oldest_ptr", buf_oldest_ptr, 12'(nwr % 16));
        clr(8'h00, 8'h01);
        chk("over_flag_ch0", over_flag_ch0, 12'h000);
        chk("under_flag_ch0", under_flag_ch0, 12'h001);
        clr(8'hff, 8'hff);
        chk("alert", alert, 12'h000);
        chk("under_flag_ch0", under_flag_ch0, 12'h000);
        $display("test history done");
        consecutive_hit_limit = 4'h0;
        restart(MODE_AFTERMATH);
        put(1'b1, 12'h001);
        put(1'b1, 12'hffe);
        chk("under_flag_ch1", under_flag_ch1, 12'h000);
        chk("over_flag_ch1", over_flag_ch1, 12'h000);
        chk("buf_oldest_ptr", buf_oldest_ptr, 12'h000);
        for (int i = 0; i < 20; i++) send(1'b1, i == 0 ? 12'h000 : i == 4 ? 12'hfff : 12'h400 + i);
        conv_valid = 1'b0;
        step(4);
        chk("under_flag_ch1", under_flag_ch1, 12'h001);
        chk("over_flag_ch1", over_flag_ch1, 12'h001);
        chk("chid", first_trigger_channel_id, 12'h001);
        chk("capture_done", capture_done, 12'h001);
        chk("wake_count", wake_count, 12'h002);
        for (int a = 0; a < 16; a++) begin
            rdchk(a, a == 0 ? 12'h000 : a == 4 ? 12'hfff : 12'h400 + a[11:0]);
        end
        $display("test aftermath done");
        // receiver stalled: two words held, third refused, then drained
        clr(8'hff, 8'hff);
        restart(MODE_OFF);
        monitor_enable = 1'b0;
        send(1'b0, 12'h065);
        send(1'b0, 12'h064);
        chk("conv_ready", conv_ready, 12'h000);
        conv_valid = 1'b0;
        step(2);
        chk("under_flag_ch0", under_flag_ch0, 12'h000);
        monitor_enable = 1'b1;
        step(4);
        chk("under_flag_ch0", under_flag_ch0, 12'h001);
        chk("chid", first_trigger_channel_id, 12'h000);
        chk("wake_count", wake_count, 12'h003);
        $display("test stall done");
        print_verdict();
    end

    initial begin
        step(5000);
        n_errors++;
        print_verdict();
    end
endmodule

`default_nettype wire

// >>> hw/sample_skid_buffer.sv
/*
 * two-entry valid/ready buffer in the conversion stream path.
 * assumes: one clock, synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module sample_skid_buffer
    import window_compare_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire window_compare_pkg::sample_t in_data,
    input wire logic in_chan,
    output logic out_valid,
    input wire logic out_ready,
    output window_compare_pkg::sample_t out_data,
    output logic out_chan
);
    sample_t data_reg [2];
    logic chan_reg [2];
    logic [1:0] count_reg;
    logic rd_ptr_reg;
    logic wr_ptr_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != 2'd2);
    assign out_valid = (count_reg != 2'd0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = data_reg[rd_ptr_reg];
    assign out_chan = chan_reg[rd_ptr_reg];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            data_reg[wr_ptr_reg] <= in_data;
            chan_reg[wr_ptr_reg] <= in_chan;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_reg <= 2'd0;
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    full_never_over_a: assert property (@(posedge sys_clk) disable iff (rst)
        count_reg <= 2'd2)
        else $error("buffer count exceeds two");
    full_holds_word_a: assert property (@(posedge sys_clk) disable iff (rst)
        (out_valid && !out_ready) |=> out_valid && $stable(out_data))
        else $error("stalled word lost or changed");
endmodule

`default_nettype wire

// >>> hw/window_compare_alert_capture.sv
/*
 * two-channel digital window comparator with consecutive-hit filter,
 * latched alert flags, first-channel record and 16-entry capture buffer.
 * assumes: conversions arrive as a valid/ready stream on sys_clk, one
 * result tagged with its channel; control bits are plain ports.
 */
// Functional notes
// R1: low side fires when result at or below low
// R2: high side fires when result at or above high
// R3: high threshold all ones fires only on full scale
// R4: low threshold zero fires only on zero
// R5: either side counts as out-of-window crossing
// R6: alert only after limit consecutive comparator hits
// R7: sixteen-entry sample buffer readable by host
// R8: history mode writes continuously until alert
// R9: history stops at alerting sample, sixteen kept
// R10: aftermath mode stores nothing before alert
// R11: aftermath stores alerting sample plus fifteen, stops
// R12: alert output driven after filtered window exit
// R13: hit requirement is shared limit field plus one
// R14: latched flags, write-one clears, all ones clears all
// R15: read-only field records first alerting channel
// R16: non-hitting conversion restarts that channel's run
`timescale 1ns/1ps
`default_nettype none
`include "window_compare_map.svh"

module window_compare_alert_capture
    import window_compare_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic conv_valid,
    output logic conv_ready,
    input wire window_compare_pkg::sample_t conv_data,
    input wire logic conv_chan,
    input wire logic monitor_enable,
    input wire window_compare_pkg::capture_mode_e capture_mode,
    input wire logic [`WC_LIMIT_W-1:0] consecutive_hit_limit,
    input wire window_compare_pkg::sample_t low_threshold_ch0,
    input wire window_compare_pkg::sample_t low_threshold_ch1,
    input wire window_compare_pkg::sample_t high_threshold_ch0,
    input wire window_compare_pkg::sample_t high_threshold_ch1,
    input wire logic flag_clear_we,
    input wire logic [7:0] under_flag_clear,
    input wire logic [7:0] over_flag_clear,
    input wire logic capture_restart,
    output logic alert,
    output logic under_flag_ch0,
    output logic under_flag_ch1,
    output logic over_flag_ch0,
    output logic over_flag_ch1,
    output logic [`WC_CHID_W-1:0] first_trigger_channel_id,
    output logic capture_done,
    input wire window_compare_pkg::buf_addr_t buf_rd_addr,
    output window_compare_pkg::sample_t buf_rd_data,
    output window_compare_pkg::buf_addr_t buf_oldest_ptr
);
    sample_t s_data;
    logic s_chan;
    logic s_valid;
    logic s_ready;
    sample_t low_sel;
    sample_t high_sel;
    logic low_hit;
    logic high_hit;
    logic hit;
    logic [4:0] need;
    logic [4:0] run_reg [`WC_NUM_CH];
    logic [4:0] run_next;
    logic trip;
    logic [`WC_NUM_CH-1:0] under_reg;
    logic [`WC_NUM_CH-1:0] over_reg;
    logic alert_reg;
    logic [`WC_CHID_W-1:0] chid_reg;
    sample_t mem [`WC_BUF_DEPTH];
    buf_addr_t wr_ptr_reg;
    logic [4:0] fill_reg;
    capture_state_e cap_reg;
    logic cap_we;

    // stream drains only while monitor_enable is high; buffer holds up to two words while it is low
    sample_skid_buffer u_skid (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(conv_valid),
        .in_ready(conv_ready),
        .in_data(conv_data),
        .in_chan(conv_chan),
        .out_valid(s_valid),
        .out_ready(s_ready),
        .out_data(s_data),
        .out_chan(s_chan)
    );

    assign s_ready = monitor_enable;
    wire take = s_valid && s_ready;

    assign low_sel = s_chan ? low_threshold_ch1 : low_threshold_ch0;
    assign high_sel = s_chan ? high_threshold_ch1 : high_threshold_ch0;
    // inclusive compares give the full-scale and zero special cases for free
    assign low_hit = (s_data <= low_sel); // R1 R4
    assign high_hit = (s_data >= high_sel); // R2 R3
    assign hit = low_hit || high_hit; // R5
    assign need = {1'b0, consecutive_hit_limit} + 5'd1; // R13

    always_comb begin
        run_next = 5'd0;
        if (hit) begin
            run_next = (run_reg[s_chan] == `WC_RUN_MAX) ? `WC_RUN_MAX
                                                         : run_reg[s_chan] + 5'd1;
        end
    end

    assign trip = take && hit && (run_next >= need); // R6

    generate
        for (genvar ch = 0; ch < `WC_NUM_CH; ch++) begin : g_ch
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    run_reg[ch] <= 5'd0;
                end else if (take && s_chan == ch) begin
                    run_reg[ch] <= run_next; // R16
                end
            end

            // set beats a same-cycle clear
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    under_reg[ch] <= 1'b0;
                    over_reg[ch] <= 1'b0;
                end else begin
                    if (trip && s_chan == ch && low_hit) begin
                        under_reg[ch] <= 1'b1; // R14
                    end else if (flag_clear_we && under_flag_clear[ch]) begin
                        under_reg[ch] <= 1'b0; // R14
                    end
                    if (trip && s_chan == ch && high_hit) begin
                        over_reg[ch] <= 1'b1; // R14
                    end else if (flag_clear_we && over_flag_clear[ch]) begin
                        over_reg[ch] <= 1'b0; // R14
                    end
                end
            end
        end
    endgenerate

    wire clear_all = flag_clear_we && (under_flag_clear == `WC_CLEAR_ALL)
                     && (over_flag_clear == `WC_CLEAR_ALL);

    // alert sets on a trip; only an all-ones clear of both fields or a restart drops it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            alert_reg <= 1'b0;
        end else if (trip) begin
            alert_reg <= 1'b1; // R12
        end else if (clear_all || capture_restart) begin
            alert_reg <= 1'b0;
        end
    end

    // a trip in the restart cycle opens the new record instead of being lost
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            chid_reg <= `WC_CHID_CH0;
        end else if (trip && (!alert_reg || capture_restart)) begin
            chid_reg <= s_chan ? `WC_CHID_CH1 : `WC_CHID_CH0; // R15
        end else if (capture_restart) begin
            chid_reg <= `WC_CHID_CH0;
        end
    end

    assign alert = alert_reg;
    assign under_flag_ch0 = under_reg[0];
    assign under_flag_ch1 = under_reg[1];
    assign over_flag_ch0 = over_reg[0];
    assign over_flag_ch1 = over_reg[1];
    assign first_trigger_channel_id = chid_reg;

    // capture sequencing; restart rearms for the mode now selected
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cap_reg <= CAP_IDLE;
        end else if (capture_restart) begin
            cap_reg <= CAP_IDLE;
        end else begin
            unique case (cap_reg)
                CAP_IDLE: begin
                    if (capture_mode == MODE_HISTORY) begin
                        cap_reg <= CAP_FILL; // R8
                    end else if (capture_mode == MODE_AFTERMATH) begin
                        cap_reg <= CAP_ARMED; // R10
                    end
                end
                CAP_ARMED: begin
                    if (trip) begin
                        cap_reg <= (fill_reg == 5'd15) ? CAP_DONE : CAP_FILL; // R11
                    end
                end
                CAP_FILL: begin
                    if (capture_mode == MODE_HISTORY && trip) begin
                        cap_reg <= CAP_DONE; // R9
                    end else if (capture_mode == MODE_AFTERMATH && take
                                 && fill_reg == 5'd15) begin
                        cap_reg <= CAP_DONE; // R11
                    end
                end
                CAP_DONE: begin
                end
            endcase
        end
    end

    assign cap_we = take && ((cap_reg == CAP_FILL)
                    || (cap_reg == CAP_ARMED && trip)); // R8 R10

    always_ff @(posedge sys_clk) begin
        if (cap_we) begin
            mem[wr_ptr_reg] <= s_data; // R7
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || capture_restart) begin
            wr_ptr_reg <= '0;
            fill_reg <= 5'd0;
        end else if (cap_we) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (fill_reg != 5'd16) begin
                fill_reg <= fill_reg + 5'd1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            buf_rd_data <= '0;
        end else begin
            buf_rd_data <= mem[buf_rd_addr]; // R7
        end
    end

    // after a wrapped history fill the oldest entry sits at the write pointer
    assign buf_oldest_ptr = wr_ptr_reg;
    assign capture_done = (cap_reg == CAP_DONE);

    low_side_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
        take && s_data <= low_sel |=> run_reg[$past(s_chan)] != 5'd0)
        else $error("low compare missed");
    high_side_a: assert property (@(posedge sys_clk) disable iff (rst) // R2
        take && s_data >= high_sel |=> run_reg[$past(s_chan)] != 5'd0)
        else $error("high compare missed");
    // off the single special code, neither compare may count a hit
    full_scale_a: assert property (@(posedge sys_clk) disable iff (rst) // R3
        take && high_sel == `WC_FULL_CODE && s_data != `WC_FULL_CODE && s_data > low_sel
        |=> run_reg[$past(s_chan)] == 5'd0)
        else $error("full scale high hit wrong");
    zero_low_a: assert property (@(posedge sys_clk) disable iff (rst) // R4
        take && low_sel == `WC_ZERO_CODE && s_data != `WC_ZERO_CODE && s_data < high_sel
        |=> run_reg[$past(s_chan)] == 5'd0)
        else $error("zero low hit wrong");
    run_needed_a: assert property (@(posedge sys_clk) disable iff (rst) // R6 R13
        trip |-> run_reg[s_chan] >= {1'b0, consecutive_hit_limit})
        else $error("alert before run limit");
    run_restart_a: assert property (@(posedge sys_clk) disable iff (rst) // R16
        take && !hit |=> run_reg[$past(s_chan)] == 5'd0)
        else $error("run count not restarted");
    alert_rise_a: assert property (@(posedge sys_clk) disable iff (rst) // R5 R12 R14
        trip |=> alert && (under_reg != 2'b00 || over_reg != 2'b00))
        else $error("trip did not raise alert and flag");
    alert_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // R12
        alert && !clear_all && !capture_restart |=> alert)
        else $error("alert dropped without clear");
    under_clear_a: assert property (@(posedge sys_clk) disable iff (rst) // R14
        flag_clear_we && under_flag_clear[0] && !(trip && !s_chan && low_hit)
        |=> !under_flag_ch0)
        else $error("low flag not cleared");
    over_clear_a: assert property (@(posedge sys_clk) disable iff (rst) // R14
        flag_clear_we && over_flag_clear[1] && !(trip && s_chan && high_hit)
        |=> !over_flag_ch1)
        else $error("high flag not cleared");
    history_stop_a: assert property (@(posedge sys_clk) // R9 R11
        disable iff (rst || capture_restart)
        cap_reg == CAP_DONE |=> !cap_we && cap_reg == CAP_DONE)
        else $error("buffer written after capture done");
    wr_step_a: assert property (@(posedge sys_clk) // R7 R8
        disable iff (rst || capture_restart)
        cap_we |=> wr_ptr_reg == $past(wr_ptr_reg) + 4'h1)
        else $error("capture pointer skipped");
    after_quiet_a: assert property (@(posedge sys_clk) disable iff (rst) // R10
        cap_reg == CAP_ARMED && !trip |-> !cap_we)
        else $error("aftermath stored before alert");
    chid_first_a: assert property (@(posedge sys_clk) // R15
        disable iff (rst || capture_restart)
        alert && $past(alert) && !$past(capture_restart) |-> $stable(chid_reg))
        else $error("first channel id changed");

    history_cap_c: cover property (@(posedge sys_clk) disable iff (rst)
        capture_mode == MODE_HISTORY && cap_reg == CAP_DONE);
    after_cap_c: cover property (@(posedge sys_clk) disable iff (rst)
        capture_mode == MODE_AFTERMATH && cap_reg == CAP_DONE);
    ch1_first_c: cover property (@(posedge sys_clk) disable iff (rst)
        chid_reg == `WC_CHID_CH1);
    set_clear_c: cover property (@(posedge sys_clk) disable iff (rst)
        trip && flag_clear_we);
    stall_full_c: cover property (@(posedge sys_clk) disable iff (rst)
        !conv_ready);
endmodule

`default_nettype wire

// >>> hw/window_compare_map.svh
/*
 * widths, codes, reset values and counts for the window
 * compare and alert capture block.
 * assumes: included by bare name, once per compilation unit.
 */
`ifndef WINDOW_COMPARE_MAP_SVH
`define WINDOW_COMPARE_MAP_SVH

`define WC_DATA_W 12
`define WC_NUM_CH 2
`define WC_BUF_DEPTH 16
`define WC_BUF_AW 4
`define WC_LIMIT_W 4
`define WC_CHID_W 4
`define WC_FULL_CODE 12'hfff
`define WC_ZERO_CODE 12'h000
`define WC_CHID_CH0 4'h0
`define WC_CHID_CH1 4'h1
`define WC_CLEAR_ALL 8'hff
`define WC_RUN_MAX 5'h1f

`endif

// >>> hw/window_compare_pkg.sv
/*
 * types shared by the window compare and alert capture block.
 * assumes: the constants header is available on the include path.
 */
`default_nettype none
`include "window_compare_map.svh"

package window_compare_pkg;
    typedef logic [`WC_DATA_W-1:0] sample_t;
    typedef logic [`WC_BUF_AW-1:0] buf_addr_t;
    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_HISTORY,
        MODE_AFTERMATH
    } capture_mode_e;
    typedef enum {
        CAP_IDLE,
        CAP_ARMED,
        CAP_FILL,
        CAP_DONE
    } capture_state_e;
endpackage

`default_nettype wire
